// [rtl/fdsel_cfg.svh]
`ifndef FDSEL_CFG_SVH
`define FDSEL_CFG_SVH
// Summary of operation
// RQ1 - in parallel floppy mode with port function select zero, drive extra drive select pin
// RQ2 - extra select carries drive one with swap bit clear, drive zero when set
// RQ3 - combined drive two-or-three select asserts for drives 2 or 3, not during exchange
// RQ4 - rate pins mirror bits 1:0 of whichever rate register was written last
// RQ5 - in parallel floppy mode with select zero, drive extra rate bit zero pin
// RQ6 - each dma request line is active high, sourced by floppy or parallel port
// RQ7 - request line floats when unsourced, source disabled, or source has no dma
// RQ8 - after reset request line 2 belongs to floppy, lines 0, 1, 3 float
// RQ9 - in alternate compatibility mode, status a shows second drive installed input
// RQ10 - disk change input readable through the digital input register
// RQ11 - mode option reuses disk change pin as read gate diagnostic input
// RQ12 - in parallel floppy mode with select zero, accept extra disk change input
// RQ13 - decoded drive selects gated by motor enable bits 7:4 of digital output register
// RQ14 - duplicated parallel outputs match value and timing of normal outputs

`define FDSEL_ADDR_W 8
`define FDSEL_OFF_DOR 8'h00
`define FDSEL_OFF_CCR 8'h04
`define FDSEL_OFF_DSR 8'h08
`define FDSEL_OFF_FCR 8'h0c
`define FDSEL_OFF_FER 8'h10
`define FDSEL_OFF_ROUTE 8'h14
`define FDSEL_OFF_STATA 8'h18
`define FDSEL_OFF_DIR 8'h1c

`define FDSEL_DOR_SEL_LSB 0
`define FDSEL_DOR_MOTOR_LSB 4
`define FDSEL_FCR_SWAP_BIT 4
`define FDSEL_FER_FDC_EN 0
`define FDSEL_FER_PAR_EN 1
`define FDSEL_FER_PFM 2
`define FDSEL_FER_PFS 3
`define FDSEL_FER_ALT 5
`define FDSEL_FER_READ_GATE_DIAG 6
`define FDSEL_FER_FDC_DMA 7
`define FDSEL_FER_PAR_DMA 8
`define FDSEL_FER_W 9
`define FDSEL_STATA_SECOND_DRIVE_PRESENT_N_BIT 6
`define FDSEL_DIR_CHG_BIT 7

`define FDSEL_RST_DOR 8'h00
`define FDSEL_RST_RATE 2'h0
`define FDSEL_RST_SWAP 1'b0
`define FDSEL_RST_FER 9'h083
`define FDSEL_RST_ROUTE 8'h10

`endif

// [rtl/fdsel_pkg.sv]
package fdsel_pkg;
    typedef enum logic [1:0] {
        FDSEL_SRC_NONE,
        FDSEL_SRC_FDC,
        FDSEL_SRC_PAR,
        FDSEL_SRC_RSVD
    } fdsel_src_t;
endpackage

// [rtl/fdsel_dma_route.sv]
`timescale 1ns/10ps
`include "fdsel_cfg.svh"
module fdsel_dma_route #(
    parameter int LINES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2*LINES-1:0] route_i,
    input wire logic fdc_en_i,
    input wire logic par_en_i,
    input wire logic fdc_dma_en_i,
    input wire logic par_dma_en_i,
    input wire logic fdc_req_i,
    input wire logic par_req_i,
    output logic [LINES-1:0] dma_req_o,
    output logic [LINES-1:0] dma_req_oe_o
);
    fdsel_pkg::fdsel_src_t src;

    always_comb begin
        src = fdsel_pkg::FDSEL_SRC_NONE;
        dma_req_o = '0;
        dma_req_oe_o = '0;
        for (int i = 0; i < LINES; i++) begin
            src = fdsel_pkg::fdsel_src_t'(route_i[2*i +: 2]);
            case (src)
                fdsel_pkg::FDSEL_SRC_FDC: begin
                    dma_req_oe_o[i] = fdc_en_i & fdc_dma_en_i; // see RQ7
                    dma_req_o[i] = fdc_en_i & fdc_dma_en_i & fdc_req_i; // see RQ6
                end
                fdsel_pkg::FDSEL_SRC_PAR: begin
                    dma_req_oe_o[i] = par_en_i & par_dma_en_i; // see RQ7
                    dma_req_o[i] = par_en_i & par_dma_en_i & par_req_i; // see RQ6
                end
                default: begin
                    // unsourced or reserved code: line floats
                    dma_req_oe_o[i] = 1'b0; // see RQ7
                    dma_req_o[i] = 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    for (genvar g = 0; g < LINES; g++) begin : g_chk
        property p_float_unsourced;
            (route_i[2*g +: 2] == 2'h0) || (route_i[2*g +: 2] == 2'h3) |-> !dma_req_oe_o[g];
        endproperty
        a_float_unsourced: assert property (p_float_unsourced) else $error("unsourced dma line driven"); // see RQ7

        property p_fdc_follow;
            (route_i[2*g +: 2] == 2'h1) && fdc_en_i && fdc_dma_en_i |-> dma_req_oe_o[g] && (dma_req_o[g] == fdc_req_i);
        endproperty
        a_fdc_follow: assert property (p_fdc_follow) else $error("dma line not following floppy request"); // see RQ6

        property p_par_off;
            (route_i[2*g +: 2] == 2'h2) && !(par_en_i && par_dma_en_i) |-> !dma_req_oe_o[g] && !dma_req_o[g];
        endproperty
        a_par_off: assert property (p_par_off) else $error("dma line driven by disabled parallel port"); // see RQ7
    end
endmodule

// [rtl/fdsel_top.sv]
`timescale 1ns/10ps
`include "fdsel_cfg.svh"
module fdsel_top #(
    parameter int DMA_LINES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`FDSEL_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic fdc_dma_req_i,
    input wire logic par_dma_req_i,
    output logic [DMA_LINES-1:0] dma_req_o,
    output logic [DMA_LINES-1:0] dma_req_oe_o,
    output logic drive_select_zero_n_o,
    output logic drive_select_one_n_o,
    output logic drive_two_or_three_n_o,
    output logic rate_bit0_n_o,
    output logic rate_bit1_n_o,
    output logic drive_select_one_pp_n_o,
    output logic rate_bit0_pp_n_o,
    output logic pp_floppy_oe_o,
    input wire logic door_opened_n_i,
    input wire logic door_opened_pp_n_i,
    input wire logic second_drive_present_n_i,
    output logic read_gate_diag_o
);
    logic setup;
    logic access;
    logic known;
    logic wr;
    logic [1:0] wr_rate;
    logic [1:0] dor_sel;
    logic [3:0] dor_motor;
    logic [1:0] rate;
    logic fcr_swap;
    logic [`FDSEL_FER_W-1:0] fer;
    logic [2*DMA_LINES-1:0] route;
    logic [1:0] next_dor_sel;
    logic [3:0] next_dor_motor;
    logic [1:0] next_rate;
    logic next_fcr_swap;
    logic [`FDSEL_FER_W-1:0] next_fer;
    logic [2*DMA_LINES-1:0] next_route;
    logic [31:0] next_prdata;
    logic pp_active;
    logic door_active;
    logic motor_on;
    logic [1:0] phys;
    logic ds0_n;
    logic ds1_n;
    logic drive_two_or_three_n_n;
    logic rate0_n;
    logic rate1_n;
    logic read_gate_diag;
    logic next_ds0_n;
    logic next_ds1_n;
    logic next_drive_two_or_three_n_n;
    logic next_rate0_n;
    logic next_rate1_n;
    logic next_read_gate_diag;
    // a literal cannot be part-selected, so the reset word is named first
    localparam logic [7:0] RST_DOR = `FDSEL_RST_DOR;

    function automatic logic fdsel_mapped(input logic [`FDSEL_ADDR_W-1:0] a);
        case (a)
            `FDSEL_OFF_DOR, `FDSEL_OFF_CCR, `FDSEL_OFF_DSR, `FDSEL_OFF_FCR,
            `FDSEL_OFF_FER, `FDSEL_OFF_ROUTE, `FDSEL_OFF_STATA, `FDSEL_OFF_DIR: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // exchange only ever trades logical drives 0 and 1
    function automatic logic [1:0] fdsel_phys(input logic [1:0] lsel, input logic swap);
        return (swap && !lsel[1]) ? {1'b0, ~lsel[0]} : lsel;
    endfunction

    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign known = fdsel_mapped(paddr_i);
    assign wr = access & pwrite_i & known;
    assign wr_rate = pwdata_i[1:0];
    // zero wait states: read data is captured in the setup cycle
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~known;

    assign pp_active = fer[`FDSEL_FER_PFM] & ~fer[`FDSEL_FER_PFS];
    assign door_active = ~door_opened_n_i | (pp_active & ~door_opened_pp_n_i); // see RQ12
    assign motor_on = dor_motor[dor_sel];
    assign phys = fdsel_phys(dor_sel, fcr_swap);

    // register file
    always_comb begin
        next_dor_sel = dor_sel;
        next_dor_motor = dor_motor;
        next_rate = rate;
        next_fcr_swap = fcr_swap;
        next_fer = fer;
        next_route = route;
        if (wr) begin
            case (paddr_i)
                `FDSEL_OFF_DOR: begin
                    next_dor_sel = pwdata_i[`FDSEL_DOR_SEL_LSB +: 2];
                    next_dor_motor = pwdata_i[`FDSEL_DOR_MOTOR_LSB +: 4];
                end
                // both rate registers share one store, so the last write wins
                `FDSEL_OFF_CCR: begin
                    next_rate = wr_rate; // see RQ4
                end
                `FDSEL_OFF_DSR: begin
                    next_rate = wr_rate; // see RQ4
                end
                `FDSEL_OFF_FCR: begin
                    next_fcr_swap = pwdata_i[`FDSEL_FCR_SWAP_BIT];
                end
                `FDSEL_OFF_FER: begin
                    next_fer = pwdata_i[`FDSEL_FER_W-1:0];
                end
                `FDSEL_OFF_ROUTE: begin
                    next_route = pwdata_i[2*DMA_LINES-1:0];
                end
                default: begin
                    next_fer = fer;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dor_sel <= RST_DOR[1:0];
            dor_motor <= RST_DOR[7:4];
            rate <= `FDSEL_RST_RATE;
            fcr_swap <= `FDSEL_RST_SWAP;
            fer <= `FDSEL_RST_FER;
            route <= `FDSEL_RST_ROUTE; // see RQ8
        end else begin
            dor_sel <= next_dor_sel;
            dor_motor <= next_dor_motor;
            rate <= next_rate;
            fcr_swap <= next_fcr_swap;
            fer <= next_fer;
            route <= next_route;
        end
    end

    // read path
    always_comb begin
        next_prdata = prdata_o;
        if (setup && !pwrite_i) begin
            case (paddr_i)
                `FDSEL_OFF_DOR: next_prdata = {24'h000000, dor_motor, 2'h0, dor_sel};
                `FDSEL_OFF_CCR: next_prdata = {30'h00000000, rate};
                `FDSEL_OFF_DSR: next_prdata = {30'h00000000, rate};
                `FDSEL_OFF_FCR: next_prdata = {27'h0000000, fcr_swap, 4'h0};
                `FDSEL_OFF_FER: next_prdata = {23'h000000, fer};
                `FDSEL_OFF_ROUTE: next_prdata = {24'h000000, route};
                `FDSEL_OFF_STATA: begin
                    next_prdata = 32'h00000000;
                    next_prdata[`FDSEL_STATA_SECOND_DRIVE_PRESENT_N_BIT] = fer[`FDSEL_FER_ALT] & ~second_drive_present_n_i; // see RQ9
                end
                `FDSEL_OFF_DIR: begin
                    next_prdata = 32'h00000000;
                    // in read gate mode the pin no longer means disk change
                    next_prdata[`FDSEL_DIR_CHG_BIT] = door_active & ~fer[`FDSEL_FER_READ_GATE_DIAG]; // see RQ10
                end
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h00000000;
        end else begin
            prdata_o <= next_prdata;
        end
    end

    // drive pins, all registered so normal and duplicated copies switch together
    always_comb begin
        next_ds0_n = ~(motor_on & (phys == 2'h0)); // see RQ13
        next_ds1_n = ~(motor_on & (phys == 2'h1)); // see RQ13
        next_drive_two_or_three_n_n = ~(motor_on & dor_sel[1] & ~fcr_swap); // see RQ3
        next_rate0_n = ~rate[0]; // see RQ4
        next_rate1_n = ~rate[1]; // see RQ4
        next_read_gate_diag = fer[`FDSEL_FER_READ_GATE_DIAG] & ~door_opened_n_i; // see RQ11
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ds0_n <= 1'b1;
            ds1_n <= 1'b1;
            drive_two_or_three_n_n <= 1'b1;
            rate0_n <= 1'b1;
            rate1_n <= 1'b1;
            read_gate_diag <= 1'b0;
        end else begin
            ds0_n <= next_ds0_n;
            ds1_n <= next_ds1_n;
            drive_two_or_three_n_n <= next_drive_two_or_three_n_n;
            rate0_n <= next_rate0_n;
            rate1_n <= next_rate1_n;
            read_gate_diag <= next_read_gate_diag;
        end
    end

    assign drive_select_zero_n_o = ds0_n;
    assign drive_select_one_n_o = ds1_n;
    assign drive_two_or_three_n_o = drive_two_or_three_n_n;
    assign rate_bit0_n_o = rate0_n;
    assign rate_bit1_n_o = rate1_n;
    assign read_gate_diag_o = read_gate_diag;
    assign pp_floppy_oe_o = pp_active; // see RQ1
    // the pin after exchange already carries logical drive 0 or 1 as needed
    assign drive_select_one_pp_n_o = ds1_n; // see RQ2
    assign rate_bit0_pp_n_o = rate0_n; // see RQ5

    fdsel_dma_route #(
        .LINES(DMA_LINES)
    ) u_dma (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .route_i(route),
        .fdc_en_i(fer[`FDSEL_FER_FDC_EN]),
        .par_en_i(fer[`FDSEL_FER_PAR_EN]),
        .fdc_dma_en_i(fer[`FDSEL_FER_FDC_DMA]),
        .par_dma_en_i(fer[`FDSEL_FER_PAR_DMA]),
        .fdc_req_i(fdc_dma_req_i),
        .par_req_i(par_dma_req_i),
        .dma_req_o(dma_req_o),
        .dma_req_oe_o(dma_req_oe_o)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_pp_enable;
        wr && (paddr_i == `FDSEL_OFF_FER) && pwdata_i[`FDSEL_FER_PFM] && !pwdata_i[`FDSEL_FER_PFS]
            |=> pp_floppy_oe_o;
    endproperty
    a_pp_enable: assert property (p_pp_enable) else $error("parallel floppy pins not enabled"); // see RQ1

    property p_pp_select;
        pp_floppy_oe_o |-> (drive_select_one_pp_n_o == drive_select_one_n_o);
    endproperty
    a_pp_select: assert property (p_pp_select) else $error("duplicated select differs"); // see RQ14

    property p_swap_clear;
        (dor_sel == 2'h1) && dor_motor[1] && !fcr_swap |=> !drive_select_one_n_o && drive_select_zero_n_o;
    endproperty
    a_swap_clear: assert property (p_swap_clear) else $error("drive one not on select one"); // see RQ2

    property p_swap_set;
        (dor_sel == 2'h0) && dor_motor[0] && fcr_swap |=> !drive_select_one_n_o && drive_select_zero_n_o;
    endproperty
    a_swap_set: assert property (p_swap_set) else $error("exchange did not move drive zero"); // see RQ2

    property p_two_or_three;
        dor_sel[1] && motor_on && !fcr_swap |=> !drive_two_or_three_n_o;
    endproperty
    a_two_or_three: assert property (p_two_or_three) else $error("drive 2/3 select missing"); // see RQ3

    property p_rate_write;
        wr && ((paddr_i == `FDSEL_OFF_CCR) || (paddr_i == `FDSEL_OFF_DSR))
            |-> ##2 ({rate_bit1_n_o, rate_bit0_n_o} == ~$past(wr_rate, 2));
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("rate pins do not follow last write"); // see RQ4

    property p_rate_pp;
        pp_floppy_oe_o |-> (rate_bit0_pp_n_o == rate_bit0_n_o);
    endproperty
    a_rate_pp: assert property (p_rate_pp) else $error("duplicated rate pin differs"); // see RQ5

    property p_motor_gate;
        (dor_motor == 4'h0) |=> drive_select_zero_n_o && drive_select_one_n_o && drive_two_or_three_n_o;
    endproperty
    a_motor_gate: assert property (p_motor_gate) else $error("select active with motors off"); // see RQ13

    property p_after_reset;
        $fell(rst_i) |-> (dma_req_oe_o == 4'h4);
    endproperty
    a_after_reset: assert property (@(posedge clk_i) p_after_reset) else $error("dma lines wrong after reset"); // see RQ8

    property p_door_read;
        setup && !pwrite_i && (paddr_i == `FDSEL_OFF_DIR) && !door_opened_n_i && !fer[`FDSEL_FER_READ_GATE_DIAG]
            |=> prdata_o[`FDSEL_DIR_CHG_BIT];
    endproperty
    a_door_read: assert property (p_door_read) else $error("disk change not readable"); // see RQ10

    property p_door_pp;
        setup && !pwrite_i && (paddr_i == `FDSEL_OFF_DIR) && pp_active && !door_opened_pp_n_i
            && !fer[`FDSEL_FER_READ_GATE_DIAG] |=> prdata_o[`FDSEL_DIR_CHG_BIT];
    endproperty
    a_door_pp: assert property (p_door_pp) else $error("extra disk change not accepted"); // see RQ12

    property p_status_a;
        setup && !pwrite_i && (paddr_i == `FDSEL_OFF_STATA)
            |=> prdata_o[`FDSEL_STATA_SECOND_DRIVE_PRESENT_N_BIT] == ($past(fer[`FDSEL_FER_ALT]) && !$past(second_drive_present_n_i));
    endproperty
    a_status_a: assert property (p_status_a) else $error("status a drive bit wrong"); // see RQ9

    property p_read_gate;
        fer[`FDSEL_FER_READ_GATE_DIAG] ##1 fer[`FDSEL_FER_READ_GATE_DIAG] |-> read_gate_diag_o == !$past(door_opened_n_i);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read gate diagnostic wrong"); // see RQ11

    c_pp_mode: cover property (pp_floppy_oe_o && !drive_select_one_pp_n_o);
    c_swap: cover property (fcr_swap && !drive_select_one_n_o);
    c_dma2: cover property (dma_req_oe_o[2] && dma_req_o[2]);
    c_read_gate_diag: cover property (read_gate_diag_o);
endmodule

// [tb/fdsel_far_model.sv]
`timescale 1ns/10ps
module fdsel_far_model (
    input wire logic door_open_i,
    input wire logic pp_door_open_i,
    input wire logic drive2_fitted_i,
    input wire logic [3:0] dma_req_i,
    input wire logic [3:0] dma_req_oe_i,
    output logic door_opened_n_o,
    output logic door_opened_pp_n_o,
    output logic second_drive_present_n_o,
    output logic [3:0] dma_line_o
);
    // drive status lines are low while the condition is true
    assign door_opened_n_o = ~door_open_i;
    assign door_opened_pp_n_o = ~pp_door_open_i;
    assign second_drive_present_n_o = ~drive2_fitted_i;
    // host side holds a pull-down, so a floating request reads idle, not the last value
    assign dma_line_o = dma_req_oe_i & dma_req_i;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "fdsel_cfg.svh"
module tb_top;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fdc_req = 1'b0, par_req = 1'b0;
    logic door = 1'b0, pp_door = 1'b0, second_drive_present_n = 1'b0;
    logic door_n, pp_door_n, second_drive_present_n_n, ds0, ds1, drive_two_or_three_n, r0, r1, pp1, ppr0, pp_oe, rgd;
    logic [3:0] dma_req, dma_oe, dma_line;
    int n_errors = 0, compares = 0, cycles = 0;

    fdsel_top dut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .fdc_dma_req_i(fdc_req), .par_dma_req_i(par_req), .dma_req_o(dma_req), .dma_req_oe_o(dma_oe),
        .drive_select_zero_n_o(ds0), .drive_select_one_n_o(ds1), .drive_two_or_three_n_o(drive_two_or_three_n),
        .rate_bit0_n_o(r0), .rate_bit1_n_o(r1), .drive_select_one_pp_n_o(pp1), .rate_bit0_pp_n_o(ppr0),
        .pp_floppy_oe_o(pp_oe), .door_opened_n_i(door_n), .door_opened_pp_n_i(pp_door_n),
        .second_drive_present_n_i(second_drive_present_n_n), .read_gate_diag_o(rgd));
    fdsel_far_model far (.door_open_i(door), .pp_door_open_i(pp_door), .drive2_fitted_i(second_drive_present_n),
        .dma_req_i(dma_req), .dma_req_oe_i(dma_oe), .door_opened_n_o(door_n),
        .door_opened_pp_n_o(pp_door_n), .second_drive_present_n_o(second_drive_present_n_n), .dma_line_o(dma_line));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one idle cycle before each setup keeps psel from being assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    // register change reaches the pins one cycle after the write lands
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        check(dma_oe, 32'h4);
        check({ds0, ds1, drive_two_or_three_n, r0, r1, pp1, ppr0, pp_oe, rgd}, 32'h1fc);
        rdc(`FDSEL_OFF_FER, 32'h83);
        rdc(`FDSEL_OFF_ROUTE, 32'h10);
        @(posedge clk);
        fdc_req <= 1'b1;
        settle();
        check(dma_line, 32'h4);
        @(posedge clk);
        fdc_req <= 1'b0;
    endtask

    task automatic t_select;
        logic [1:0] ph;
        logic [3:0] mot;
        for (int s = 0; s < 2; s++) begin
            wr(`FDSEL_OFF_FCR, 32'(s) << 4);
            for (int d = 0; d < 4; d++) begin
                for (int m = 0; m < 2; m++) begin
                    ph = (s == 1 && d < 2) ? 2'(1 - d) : 2'(d);
                    // motor off only for the selected drive: any other bit must not open it
                    mot = (m == 1) ? 4'hf : ~(4'h1 << d);
                    wr(`FDSEL_OFF_DOR, {24'h0, mot, 2'b00, 2'(d)});
                    settle();
                    check(ds0, !(m == 1 && ph == 2'd0));
                    check(ds1, !(m == 1 && ph == 2'd1));
                    check(pp1, ds1);
                    if (m == 1) check(drive_two_or_three_n, !(d >= 2 && s == 0));
                end
            end
        end
    endtask

    task automatic t_rate;
        logic [1:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 2'(i) ^ 2'h2;
            wr(i[0] ? `FDSEL_OFF_DSR : `FDSEL_OFF_CCR, {30'h0, v});
            settle();
            check({30'h0, r1, r0}, {30'h0, ~v});
            check(ppr0, r0);
            rdc(i[0] ? `FDSEL_OFF_CCR : `FDSEL_OFF_DSR, {30'h0, v});
        end
    endtask

    task automatic t_status;
        logic [31:0] r;
        logic e;
        @(posedge clk);
        second_drive_present_n <= 1'b1;
        door <= 1'b1;
        wr(`FDSEL_OFF_FER, 32'ha3);
        settle();
        rdc(`FDSEL_OFF_STATA, 32'h40);
        rdc(`FDSEL_OFF_DIR, 32'h80);
        wr(`FDSEL_OFF_FER, 32'hc3);
        settle();
        rdc(`FDSEL_OFF_STATA, 32'h0);
        rdc(`FDSEL_OFF_DIR, 32'h0);
        check(rgd, 32'h1);
        @(posedge clk);
        door <= 1'b0;
        settle();
        check(rgd, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
    endtask

    task automatic t_pp;
        @(posedge clk);
        pp_door <= 1'b1;
        wr(`FDSEL_OFF_FER, 32'h87);
        settle();
        check(pp_oe, 32'h1);
        rdc(`FDSEL_OFF_DIR, 32'h80);
        wr(`FDSEL_OFF_FER, 32'h8f);
        settle();
        check(pp_oe, 32'h0);
        rdc(`FDSEL_OFF_DIR, 32'h0);
        @(posedge clk);
        pp_door <= 1'b0;
    endtask

    task automatic t_dma;
        logic [8:0] fer [5] = '{9'h183, 9'h182, 9'h103, 9'h083, 9'h181};
        logic [3:0] oe [5] = '{4'h3, 4'h2, 4'h2, 4'h1, 4'h1};
        wr(`FDSEL_OFF_ROUTE, 32'hc9);
        for (int i = 0; i < 5; i++) begin
            wr(`FDSEL_OFF_FER, {23'h0, fer[i]});
            for (int q = 0; q < 4; q++) begin
                @(posedge clk);
                fdc_req <= q[0];
                par_req <= q[1];
                #1;
                check(dma_oe, oe[i]);
                check(dma_line, oe[i] & {2'b00, q[1], q[0]});
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_select();
        t_rate();
        t_status();
        t_pp();
        t_dma();
        print_verdict();
    end
endmodule
